// ---- hw/trim_bank_pkg.sv ----
// trim bank package: register offsets, field layout and reset values
// assumes byte-wide register port, 15-bit byte addresses
`default_nettype none
package trim_bank_pkg;

   // register byte offsets; 16-bit registers take two bytes, low byte first
   localparam logic [14:0] CORE3_IND_OFFSET_TRIM_ADDR    = 15'h033A;
   localparam logic [14:0] CORE4_OFFSET_TRIM_ADDR        = 15'h033C;
   localparam logic [14:0] CORE5_OFFSET_TRIM_ADDR        = 15'h033E;
   localparam logic [14:0] CORE0_FINE_GAIN_TRIM_ADDR     = 15'h0360;
   localparam logic [14:0] CORE1_FINE_GAIN_TRIM_ADDR     = 15'h0361;
   localparam logic [14:0] CORE2_INA_FINE_GAIN_TRIM_ADDR = 15'h0362;
   localparam logic [14:0] CORE2_INB_FINE_GAIN_TRIM_ADDR = 15'h0363;
   localparam logic [14:0] CORE3_INC_FINE_GAIN_TRIM_ADDR = 15'h0364;
   localparam logic [14:0] CORE3_IND_FINE_GAIN_TRIM_ADDR = 15'h0365;
   localparam logic [14:0] CORE4_FINE_GAIN_TRIM_ADDR     = 15'h0366;
   localparam logic [14:0] CORE5_FINE_GAIN_TRIM_ADDR     = 15'h0367;

   // storage cells: six offset bytes then eight gain bytes
   localparam int          OFFSET_BYTES = 6;
   localparam int          GAIN_BYTES   = 8;
   localparam int          CELL_COUNT   = 14;

   // field layout
   localparam int          OFFSET_MSB       = 11;
   localparam int          OFFSET_HI_MSB    = 3;
   localparam int          GAIN_MSB         = 4;

   // reset value of every field
   localparam logic [7:0]  TRIM_RESET = 8'h00;

   // serial frame layout
   localparam logic [4:0]  HDR_LAST_BIT  = 5'h0F;
   localparam logic [4:0]  DATA_LAST_BIT = 5'h07;

   typedef enum logic [0:0] {PH_HEADER, PH_DATA} phase_t;

endpackage
`default_nettype wire

// ---- hw/trim_byte_cell.sv ----
// trim_byte_cell: one byte of trim storage with a host write port and a fuse load port
// assumes both write ports are on ref_clk; host write has priority
`timescale 1ns/1ps
`default_nettype none
module trim_byte_cell #(
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       host_wr,
   input  wire logic [7:0] host_data,
   input  wire logic       fuse_wr,
   input  wire logic [7:0] fuse_data,
   output logic      [7:0] value
);

   logic [7:0] value_reg;
   logic [7:0] value_next;

   // host write wins so software changes made during a late fuse load stick
   assign value_next = host_wr ? host_data : (fuse_wr ? fuse_data : value_reg);
   assign value      = value_reg;

   // whole byte kept, reserved bits too, so readback matches the write
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         value_reg <= RESET_VALUE;
      end else begin
         value_reg <= value_next;
      end
   end

endmodule
`default_nettype wire

// ---- hw/trim_bank.sv ----
// trim_bank: offset and fine gain trim registers behind the serial register port
// assumes sclk is slower than ref_clk / 8 so every pin edge is seen after sync
//
// Functional notes
// - core 3 has its own 12-bit offset trim in bits 11:0 used while it samples input D.
// - core 4 has its own 12-bit offset trim in bits 11:0.
// - core 5 has its own 12-bit offset trim in bits 11:0.
// - cores 0, 1, 4 and 5 each have a 5-bit fine gain trim in bits 4:0 of an 8-bit register.
// - core 2 keeps two fine gain trims, one applied for input A and one for input B.
// - core 3 keeps two fine gain trims, one applied for input C and one for input D.
// - the trims reset to zero and take their defaults from the fuse memory load.
// - each 12-bit offset trim is an unsigned number.
`timescale 1ns/1ps
`default_nettype none
module trim_bank (
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   // serial register port pins
   input  wire logic        sclk,
   input  wire logic        sen_n,
   input  wire logic        sdi,
   output logic             sdo,
   output logic             sdo_oe,
   // fuse memory loader, same clock
   input  wire logic        fuse_wr,
   input  wire logic [14:0] fuse_addr,
   input  wire logic [7:0]  fuse_data,
   // input selection from the datapath, same clock
   input  wire logic        core2_samples_inb,
   input  wire logic        core3_samples_ind,
   // trims to the datapath; static except the core 2 and core 3 applied gains
   output logic      [11:0] core3_ind_offset_value,
   output logic      [11:0] core4_offset_value,
   output logic      [11:0] core5_offset_value,
   output logic      [4:0]  core0_fine_gain_value,
   output logic      [4:0]  core1_fine_gain_value,
   output logic      [4:0]  core2_ina_fine_gain_value,
   output logic      [4:0]  core2_inb_fine_gain_value,
   output logic      [4:0]  core3_inc_fine_gain_value,
   output logic      [4:0]  core3_ind_fine_gain_value,
   output logic      [4:0]  core4_fine_gain_value,
   output logic      [4:0]  core5_fine_gain_value,
   output logic      [4:0]  core2_fine_gain_applied,
   output logic      [4:0]  core3_fine_gain_applied
);

   ////////////////////////////////////////////////////////////////////////////
   // reset release and pin synchronisers

   logic [1:0] rst_sync_reg;
   logic       rst_n;
   logic [1:0] sclk_sync_reg;
   logic [1:0] sen_sync_reg;
   logic [1:0] sdi_sync_reg;
   logic       sclk_prev_reg;

   assign rst_n = rst_sync_reg[1];

   // async assert, release after two edges
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   // only the second stage of each chain is read by the logic below
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_sync_reg <= 2'h0;
         sen_sync_reg  <= 2'h3;
         sdi_sync_reg  <= 2'h0;
         sclk_prev_reg <= 1'b0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[0], sclk};
         sen_sync_reg  <= {sen_sync_reg[0], sen_n};
         sdi_sync_reg  <= {sdi_sync_reg[0], sdi};
         sclk_prev_reg <= sclk_sync_reg[1];
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic frame_on;
   logic sdi_bit;

   assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
   assign sclk_fall = ~sclk_sync_reg[1] & sclk_prev_reg;
   assign frame_on  = ~sen_sync_reg[1];
   assign sdi_bit   = sdi_sync_reg[1];

   ////////////////////////////////////////////////////////////////////////////
   // serial frame: read flag, 15-bit address, then bytes with address step

   trim_bank_pkg::phase_t phase_reg;
   trim_bank_pkg::phase_t phase_next;
   logic [4:0]  bit_cnt_reg;
   logic [4:0]  bit_cnt_next;
   logic [14:0] hdr_reg;
   logic [14:0] hdr_next;
   logic [6:0]  rx_reg;
   logic [6:0]  rx_next;
   logic        read_reg;
   logic        read_next;
   logic [14:0] addr_reg;
   logic [14:0] addr_next;
   logic [7:0]  tx_reg;
   logic [7:0]  tx_next;

   logic        hdr_done;
   logic        byte_done;
   logic [14:0] hdr_addr;
   logic [14:0] step_addr;
   logic [14:0] load_addr;
   logic [7:0]  rx_byte;
   logic        host_wr;
   logic [7:0]  rd_byte;

   assign hdr_done  = sclk_rise & (phase_reg == trim_bank_pkg::PH_HEADER)
                    & (bit_cnt_reg == trim_bank_pkg::HDR_LAST_BIT);
   assign byte_done = sclk_rise & (phase_reg == trim_bank_pkg::PH_DATA)
                    & (bit_cnt_reg == trim_bank_pkg::DATA_LAST_BIT);
   assign hdr_addr  = {hdr_reg[13:0], sdi_bit};
   assign step_addr = addr_reg + 15'h0001;
   assign load_addr = hdr_done ? hdr_addr : step_addr;
   assign rx_byte   = {rx_reg, sdi_bit};
   assign host_wr   = frame_on & byte_done & ~read_reg;

   // next-state terms; a deasserted enable abandons any partial byte
   assign phase_next   = !frame_on ? trim_bank_pkg::PH_HEADER :
                         hdr_done  ? trim_bank_pkg::PH_DATA : phase_reg;
   assign bit_cnt_next = !frame_on ? 5'h00 :
                         (hdr_done | byte_done) ? 5'h00 :
                         sclk_rise ? bit_cnt_reg + 5'h01 : bit_cnt_reg;
   assign hdr_next     = (frame_on & sclk_rise & (phase_reg == trim_bank_pkg::PH_HEADER))
                         ? {hdr_reg[13:0], sdi_bit} : hdr_reg;
   assign read_next    = hdr_done ? hdr_reg[14] : read_reg;
   assign rx_next      = (frame_on & sclk_rise & (phase_reg == trim_bank_pkg::PH_DATA))
                         ? rx_byte[6:0] : rx_reg;
   assign addr_next    = hdr_done ? hdr_addr : (byte_done ? step_addr : addr_reg);
   // load fresh read byte at each byte start, shift on later falling edges
   assign tx_next      = (hdr_done | byte_done) ? rd_byte :
                         (sclk_fall & (phase_reg == trim_bank_pkg::PH_DATA)
                          & (bit_cnt_reg != 5'h00)) ? {tx_reg[6:0], 1'b0} : tx_reg;

   logic [7:0] rd_byte_at_load;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg   <= trim_bank_pkg::PH_HEADER;
         bit_cnt_reg <= 5'h00;
         hdr_reg     <= 15'h0000;
         rx_reg      <= 7'h00;
         read_reg    <= 1'b0;
         addr_reg    <= 15'h0000;
         tx_reg      <= 8'h00;
      end else begin
         phase_reg   <= phase_next;
         bit_cnt_reg <= bit_cnt_next;
         hdr_reg     <= hdr_next;
         rx_reg      <= rx_next;
         read_reg    <= read_next;
         addr_reg    <= addr_next;
         tx_reg      <= tx_next;
      end
   end

   // pin driven only while a read frame is in its data phase
   assign sdo    = tx_reg[7];
   assign sdo_oe = frame_on & read_reg & (phase_reg == trim_bank_pkg::PH_DATA);

   ////////////////////////////////////////////////////////////////////////////
   // storage cells and address decode

   logic [7:0] cell_value [trim_bank_pkg::CELL_COUNT];
   logic [trim_bank_pkg::CELL_COUNT-1:0] hit_load;

   genvar i;
   generate
      for (i = 0; i < trim_bank_pkg::CELL_COUNT; i++) begin : g_cell
         localparam logic [14:0] CELL_ADDR = (i < trim_bank_pkg::OFFSET_BYTES)
            ? trim_bank_pkg::CORE3_IND_OFFSET_TRIM_ADDR + 15'(i)
            : trim_bank_pkg::CORE0_FINE_GAIN_TRIM_ADDR + 15'(i - trim_bank_pkg::OFFSET_BYTES);
         logic cell_host_wr;
         logic cell_fuse_wr;
         assign cell_host_wr = host_wr & (addr_reg == CELL_ADDR);
         assign cell_fuse_wr = fuse_wr & (fuse_addr == CELL_ADDR);
         assign hit_load[i]  = (load_addr == CELL_ADDR);
         trim_byte_cell #(
            .RESET_VALUE (trim_bank_pkg::TRIM_RESET)
         ) u_cell (
            .ref_clk   (ref_clk),
            .rst_n     (rst_n),
            .host_wr   (cell_host_wr),
            .host_data (rx_byte),
            .fuse_wr   (cell_fuse_wr),
            .fuse_data (fuse_data),
            .value     (cell_value[i])
         );
      end
   endgenerate

   // readback mux; unmapped bytes read zero
   always_comb begin
      rd_byte_at_load = 8'h00;
      for (int k = 0; k < trim_bank_pkg::CELL_COUNT; k++) begin
         if (hit_load[k]) begin
            rd_byte_at_load = cell_value[k];
         end
      end
   end
   assign rd_byte = rd_byte_at_load;

   ////////////////////////////////////////////////////////////////////////////
   // trim fields to the datapath; offsets are plain unsigned, reserved bits dropped

   // reserved bits are stored but never steer the datapath
   assign core3_ind_offset_value = {cell_value[1][trim_bank_pkg::OFFSET_HI_MSB:0],
                                    cell_value[0]};
   assign core4_offset_value     = {cell_value[3][trim_bank_pkg::OFFSET_HI_MSB:0],
                                    cell_value[2]};
   assign core5_offset_value     = {cell_value[5][trim_bank_pkg::OFFSET_HI_MSB:0],
                                    cell_value[4]};

   assign core0_fine_gain_value     = cell_value[6][trim_bank_pkg::GAIN_MSB:0];
   assign core1_fine_gain_value     = cell_value[7][trim_bank_pkg::GAIN_MSB:0];
   assign core2_ina_fine_gain_value = cell_value[8][trim_bank_pkg::GAIN_MSB:0];
   assign core2_inb_fine_gain_value = cell_value[9][trim_bank_pkg::GAIN_MSB:0];
   assign core3_inc_fine_gain_value = cell_value[10][trim_bank_pkg::GAIN_MSB:0];
   assign core3_ind_fine_gain_value = cell_value[11][trim_bank_pkg::GAIN_MSB:0];
   assign core4_fine_gain_value     = cell_value[12][trim_bank_pkg::GAIN_MSB:0];
   assign core5_fine_gain_value     = cell_value[13][trim_bank_pkg::GAIN_MSB:0];

   // per-input gain selection follows the datapath's input choice
   assign core2_fine_gain_applied = core2_samples_inb ? core2_inb_fine_gain_value
                                                      : core2_ina_fine_gain_value;
   assign core3_fine_gain_applied = core3_samples_ind ? core3_ind_fine_gain_value
                                                      : core3_inc_fine_gain_value;

endmodule
`default_nettype wire

// ---- sim/trim_bank_sva.sv ----
// checker for trim_bank: fuse loads, gain selection and the idle serial port
// assumes it is bound to trim_bank and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module trim_bank_sva (
   input wire logic        ref_clk,
   input wire logic        arst_n,
   input wire logic        sen_n,
   input wire logic        sdo_oe,
   input wire logic        fuse_wr,
   input wire logic [14:0] fuse_addr,
   input wire logic [7:0]  fuse_data,
   input wire logic        core2_samples_inb,
   input wire logic        core3_samples_ind,
   input wire logic [11:0] core3_ind_offset_value,
   input wire logic [11:0] core4_offset_value,
   input wire logic [11:0] core5_offset_value,
   input wire logic [4:0]  core0_fine_gain_value,
   input wire logic [4:0]  core2_ina_fine_gain_value,
   input wire logic [4:0]  core2_inb_fine_gain_value,
   input wire logic [4:0]  core3_inc_fine_gain_value,
   input wire logic [4:0]  core3_ind_fine_gain_value,
   input wire logic [4:0]  core2_fine_gain_applied,
   input wire logic [4:0]  core3_fine_gain_applied
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   //////////////////////////////////////////////////////////////////////////////////////////
   // fuse loads only while the port is idle, so no host write can win the cycle
   wire logic fuse_g0 = fuse_wr && sen_n && fuse_addr == trim_bank_pkg::CORE0_FINE_GAIN_TRIM_ADDR;
   wire logic fuse_3d = fuse_wr && sen_n && fuse_addr == trim_bank_pkg::CORE3_IND_OFFSET_TRIM_ADDR;
   wire logic fuse_4h = fuse_wr && sen_n &&
                        fuse_addr == trim_bank_pkg::CORE4_OFFSET_TRIM_ADDR + 15'h0001;
   //////////////////////////////////////////////////////////////////////////////////////////
   property p_reset_zero;
      $rose(arst_n) |-> core4_offset_value == 12'h000 && core0_fine_gain_value == 5'h00 && !sdo_oe;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("trim not zero after reset");
   property p_g2_sel;
      core2_fine_gain_applied ==
         (core2_samples_inb ? core2_inb_fine_gain_value : core2_ina_fine_gain_value);
   endproperty
   a_g2_sel: assert property (p_g2_sel) else $error("core 2 gain select wrong");
   property p_g3_sel;
      core3_fine_gain_applied ==
         (core3_samples_ind ? core3_ind_fine_gain_value : core3_inc_fine_gain_value);
   endproperty
   a_g3_sel: assert property (p_g3_sel) else $error("core 3 gain select wrong");
   property p_fuse_g0;
      fuse_g0 |=> {3'h0, core0_fine_gain_value} == ($past(fuse_data) & 8'h1F);
   endproperty
   a_fuse_g0: assert property (p_fuse_g0) else $error("gain fuse load lost");
   property p_fuse_3d;
      fuse_3d |=> core3_ind_offset_value[7:0] == $past(fuse_data);
   endproperty
   a_fuse_3d: assert property (p_fuse_3d) else $error("offset low fuse load lost");
   property p_fuse_4h;
      fuse_4h |=> {4'h0, core4_offset_value[11:8]} == ($past(fuse_data) & 8'h0F);
   endproperty
   a_fuse_4h: assert property (p_fuse_4h) else $error("offset high fuse load lost");
   property p_idle_hold;
      (sen_n && !fuse_wr) [*8] |=> $stable(core5_offset_value);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("trim moved while idle");
   property p_oe_idle;
      sen_n [*6] |-> !sdo_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("sdo driven outside a frame");
   c_fuse: cover property (fuse_g0);
   c_read: cover property ($rose(sdo_oe));
   c_sel_b: cover property (core2_samples_inb && core2_fine_gain_applied != 5'h00);
endmodule
bind trim_bank trim_bank_sva sva_u (.ref_clk, .arst_n, .sen_n, .sdo_oe, .fuse_wr, .fuse_addr,
   .fuse_data, .core2_samples_inb, .core3_samples_ind, .core3_ind_offset_value,
   .core4_offset_value, .core5_offset_value, .core0_fine_gain_value,
   .core2_ina_fine_gain_value, .core2_inb_fine_gain_value, .core3_inc_fine_gain_value,
   .core3_ind_fine_gain_value, .core2_fine_gain_applied, .core3_fine_gain_applied);
`default_nettype wire

// ---- sim/tb_trim_bank.sv ----
// testbench for trim_bank: serial writes and reads, fuse loads, gain selection
// assumes sclk phases of 5 ref_clk cycles and idle gaps of 8 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_trim_bank;
   logic        ref_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        sclk = 1'b0;
   logic        sen_n = 1'b1;
   logic        sdi = 1'b0;
   logic        fuse_wr = 1'b0;
   logic [14:0] fuse_addr = 15'h0000;
   logic [7:0]  fuse_data = 8'h00;
   logic        core2_samples_inb = 1'b0;
   logic        core3_samples_ind = 1'b0;
   logic        sdo;
   logic        sdo_oe;
   logic [11:0] ofs [3];
   logic [4:0]  gv [8];
   logic [4:0]  app2;
   logic [4:0]  app3;
   int          failures = 0;
   int          total_checks = 0;
   trim_bank dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .sclk(sclk), .sen_n(sen_n), .sdi(sdi),
      .sdo(sdo), .sdo_oe(sdo_oe), .fuse_wr(fuse_wr), .fuse_addr(fuse_addr),
      .fuse_data(fuse_data), .core2_samples_inb(core2_samples_inb),
      .core3_samples_ind(core3_samples_ind), .core3_ind_offset_value(ofs[0]),
      .core4_offset_value(ofs[1]), .core5_offset_value(ofs[2]),
      .core0_fine_gain_value(gv[0]), .core1_fine_gain_value(gv[1]),
      .core2_ina_fine_gain_value(gv[2]), .core2_inb_fine_gain_value(gv[3]),
      .core3_inc_fine_gain_value(gv[4]), .core3_ind_fine_gain_value(gv[5]),
      .core4_fine_gain_value(gv[6]), .core5_fine_gain_value(gv[7]),
      .core2_fine_gain_applied(app2), .core3_fine_gain_applied(app3));
   //////////////////////////////////////////////////////////////////////////////////////////
   // clock and a watchdog against a hung run
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (100000) @(posedge ref_clk);
      failures++;
      end_sim();
   end
   //////////////////////////////////////////////////////////////////////////////////////////
   // inputs always move 1 ns after the rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one byte frame; sdo is taken late in the low phase, well after the pin settles
   task automatic frame(input logic rw, input logic [14:0] addr, input logic [7:0] wd,
                        output logic [7:0] rd);
      logic [23:0] bits;
      bits = {rw, addr, wd};
      sen_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sclk = 1'b0;
         sdi = bits[i];
         cyc(5);
         if (i < 8) rd[i] = sdo;
         if (rw && i < 8) chk("sdo_oe", 12'h001, {11'h000, sdo_oe});
         sclk = 1'b1;
         cyc(5);
      end
      sclk = 1'b0;
      cyc(5);
      sen_n = 1'b1;
      cyc(8);
   endtask
   task automatic wr(input logic [14:0] addr, input logic [7:0] d);
      logic [7:0] unused;
      frame(1'b0, addr, d, unused);
   endtask
   task automatic rdchk(input string name, input logic [14:0] addr, input logic [7:0] exp);
      logic [7:0] v;
      frame(1'b1, addr, 8'h00, v);
      chk(name, {4'h0, exp}, {4'h0, v});
   endtask
   task automatic rst();
      arst_n = 1'b0;
      cyc(3);
      arst_n = 1'b1;
      cyc(6);
   endtask
   //////////////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      for (int k = 0; k < 3; k++) chk("offset", 12'h000, ofs[k]);
      for (int k = 0; k < 8; k++) chk("gain", 12'h000, {7'h00, gv[k]});
      rdchk("read core3_ind_fine_gain_trim", trim_bank_pkg::CORE3_IND_FINE_GAIN_TRIM_ADDR, 8'h00);
   endtask
   // all gains back to back, then every one checked so no write disturbs another
   task automatic t_gains();
      for (int k = 0; k < 8; k++) wr(trim_bank_pkg::CORE0_FINE_GAIN_TRIM_ADDR + 15'(k),
                                     8'(8'h1F - k));
      for (int k = 0; k < 8; k++) begin
         chk("gain out", 12'(12'h01F - k), {7'h00, gv[k]});
         rdchk("gain read", trim_bank_pkg::CORE0_FINE_GAIN_TRIM_ADDR + 15'(k),
               8'(8'h1F - k));
      end
   endtask
   task automatic t_select();
      for (int s = 0; s < 2; s++) begin
         core2_samples_inb = s[0];
         core3_samples_ind = s[0];
         cyc(1);
         chk("core2 applied", s[0] ? 12'h01C : 12'h01D, {7'h00, app2});
         chk("core3 applied", s[0] ? 12'h01A : 12'h01B, {7'h00, app3});
      end
   endtask
   // full-scale, msb-only and mixed values: the field is plain unsigned
   // no offset calibration ever runs here, so the offset trims are free to touch
   task automatic t_offsets();
      logic [11:0] v [3];
      logic [14:0] a;
      v = '{12'hFFF, 12'h800, 12'h5A3};
      for (int k = 0; k < 3; k++) begin
         a = trim_bank_pkg::CORE3_IND_OFFSET_TRIM_ADDR + 15'(2 * k);
         wr(a, v[k][7:0]);
         wr(a + 15'h0001, {4'h0, v[k][11:8]});
         chk("offset out", v[k], ofs[k]);
         rdchk("offset lo", a, v[k][7:0]);
         rdchk("offset hi", a + 15'h0001, {4'h0, v[k][11:8]});
      end
   endtask
   task automatic t_unmapped();
      wr(15'h0340, 8'h77);
      rdchk("unmapped", 15'h0340, 8'h00);
      chk("offset kept", 12'h5A3, ofs[2]);
   endtask
   // three fuse loads back to back, each byte landing alone
   task automatic t_fuse();
      fuse_wr = 1'b1;
      fuse_addr = trim_bank_pkg::CORE0_FINE_GAIN_TRIM_ADDR;
      fuse_data = 8'h0B;
      cyc(1);
      fuse_addr = trim_bank_pkg::CORE3_IND_OFFSET_TRIM_ADDR;
      fuse_data = 8'h34;
      cyc(1);
      fuse_addr = trim_bank_pkg::CORE4_OFFSET_TRIM_ADDR + 15'h0001;
      fuse_data = 8'h07;
      cyc(1);
      fuse_wr = 1'b0;
      cyc(1);
      chk("fuse core0_fine_gain_trim", 12'h00B, {7'h00, gv[0]});
      chk("fuse core3_ind_offset_trim", 12'hF34, ofs[0]);
      chk("fuse core4_offset_trim", 12'h700, ofs[1]);
   endtask
   task automatic end_sim();
      if (failures == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      rst();
      t_reset();
      t_gains();
      t_select();
      t_offsets();
      t_unmapped();
      t_fuse();
      rst();
      t_reset();
      end_sim();
   end
endmodule
`default_nettype wire
